// File: shared/qsrs_defs.svh
// Purpose: timing counts and codes for the quad supply reset supervisor
// Assumes: 50 MHz clock, 20 ns period
// Notes:   counts above 4096 cycles are also top-level parameters
//
// Overview of operation
// RULE1: Any channel fault pulls reset low immediately.
// RULE2: All good: hold reset timeout, then release.
// RULE3: Adjust modes compare 0.5V; negative inverts polarity.
// RULE4: Power-up decodes 4-bit threshold code per channel.
// RULE5: Inhibit asserted forces reset output high.
// RULE6: Manual reset debounced, low resets, timed release.
// RULE7: Processor kicks watchdog within every upper timeout.
// RULE8: Upper timeout 1.6s fixed, else capacitor set.
// RULE9: Expiry pulls fault and reset; one timeout release.
// RULE10: Three-state select picks initial watchdog timeout.
// RULE11: Channel good flags follow comparators, undelayed.
// RULE12: Reset low until configured, then until good.
// RULE13: Initial timeout: low x1, open x8, high x64.
// RULE14: Watchdog runs unreset; fault cleared by kick/undervoltage.
// RULE15: Sample program inputs 500us once, then enable comparators.
// RULE16: Watchdog pin to ground disables watchdog entirely.
// RULE17: Timers are parameterised counters; inputs synchronised.
// RULE18: Kicks ignored in reset; restart with initial timeout.
`ifndef QSRS_DEFS_SVH
`define QSRS_DEFS_SVH

`define QSRS_CLK_HZ          50000000
`define QSRS_RST_TIMEOUT_MS  200
// Counts are written out: the products overflow 32-bit integer arithmetic
`define QSRS_RST_CYCLES      40'h0000989680
`define QSRS_WDT_UPPER_MS    1600
`define QSRS_WDT_CYCLES      40'h0004c4b400
`define QSRS_CFG_US          500
`define QSRS_CFG_CYCLES      40'h00000061a8
`define QSRS_DEB_US          1000
`define QSRS_DEB_CYCLES      40'h000000c350
`define QSRS_CNT_W           40
`define QSRS_CODE_POS_ADJ    4'hf
`define QSRS_CODE_NEG_ADJ    4'h0

`endif

// File: shared/qsrs_pkg.sv
// Purpose: types for the quad supply reset supervisor
// Assumes: nothing
// Notes:   constants live in qsrs_defs.svh
package qsrs_pkg;
    typedef enum logic [1:0] {
        QSRS_SEL_LOW,
        QSRS_SEL_OPEN,
        QSRS_SEL_HIGH
    } qsrs_sel_t;

    typedef enum logic [1:0] {
        QSRS_PIN_GND,
        QSRS_PIN_CAP,
        QSRS_PIN_SUPPLY
    } qsrs_pin_t;

    typedef enum logic [1:0] {
        QSRS_ST_CONFIG,
        QSRS_ST_HOLD,
        QSRS_ST_TIMING,
        QSRS_ST_RUN
    } qsrs_state_t;
endpackage : qsrs_pkg

// File: src/qsrs_supervisor.sv
// Purpose: reset supervisor for four supply channels with watchdog
// Assumes: comparators are outside; each gives raw above-threshold levels
// Notes:   capacitor-set delays arrive as cycle counts on ports
`timescale 1ns/1ps
`default_nettype none
`include "qsrs_defs.svh"

module qsrs_supervisor #(
    parameter logic [39:0] RST_CYCLES = 40'(`QSRS_RST_CYCLES),
    parameter logic [39:0] WDT_CYCLES = 40'(`QSRS_WDT_CYCLES),
    parameter logic [39:0] CFG_CYCLES = 40'(`QSRS_CFG_CYCLES),
    parameter logic [39:0] DEB_CYCLES = 40'(`QSRS_DEB_CYCLES)
) (
    // Clock and power-on reset
    input  wire  logic                clk,
    input  wire  logic                rst,
    // Channel comparators and program codes
    input  wire  logic [3:0]          above_threshold,
    input  wire  logic [15:0]         threshold_program_inputs,
    // Control pins
    input  wire  logic                manual_reset_n,
    input  wire  logic                reset_inhibit_n,
    input  wire  logic                watchdog_kick,
    input  wire  qsrs_pkg::qsrs_sel_t initial_timeout_select,
    input  wire  qsrs_pkg::qsrs_pin_t watchdog_period_pin,
    input  wire  logic                reset_delay_is_cap,
    input  wire  logic [39:0]         cap_reset_cycles,
    input  wire  logic [39:0]         cap_watchdog_cycles,
    // Outputs
    output logic                      system_reset_n,
    output logic                      watchdog_fault_n,
    output logic [3:0]                channel_good_flags,
    output logic [15:0]               threshold_codes,
    output logic                      config_done
);

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic [3:0] ch_s1_ff, ch_s2_ff, ch_s3_ff;
    logic [2:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
    logic [3:0] ch_ok_ff;
    logic       mr_lvl_ff, inh_lvl_ff, kick_lvl_ff;

    always_ff @(posedge clk) begin // [RULE17]
        if (rst) begin
            ch_s1_ff <= 4'h0;
            ch_s2_ff <= 4'h0;
            ch_s3_ff <= 4'h0;
        end else begin
            ch_s1_ff <= above_threshold;
            ch_s2_ff <= ch_s1_ff;
            ch_s3_ff <= ch_s2_ff;
        end
    end

    // Kick idles low after reset, so no false edge follows it
    always_ff @(posedge clk) begin // [RULE17]
        if (rst) begin
            pin_s1_ff <= 3'h3;
            pin_s2_ff <= 3'h3;
            pin_s3_ff <= 3'h3;
        end else begin
            pin_s1_ff <= {watchdog_kick, reset_inhibit_n, manual_reset_n};
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
        end
    end

    // A change counts only once stages two and three agree
    always_ff @(posedge clk) begin // [RULE17]
        if (rst) begin
            ch_ok_ff <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (ch_s2_ff[i] == ch_s3_ff[i])
                    ch_ok_ff[i] <= ch_s3_ff[i];
            end
        end
    end

    always_ff @(posedge clk) begin // [RULE17]
        if (rst) begin
            mr_lvl_ff   <= 1'b1;
            inh_lvl_ff  <= 1'b1;
            kick_lvl_ff <= 1'b0;
        end else begin
            if (pin_s2_ff[0] == pin_s3_ff[0]) mr_lvl_ff   <= pin_s3_ff[0];
            if (pin_s2_ff[1] == pin_s3_ff[1]) inh_lvl_ff  <= pin_s3_ff[1];
            if (pin_s2_ff[2] == pin_s3_ff[2]) kick_lvl_ff <= pin_s3_ff[2];
        end
    end

    // ------------------------------------------------------------
    // Counter helpers
    // ------------------------------------------------------------
    // A zero length counts as done at once, so a zero capacitor count cannot hang a timer
    function automatic logic cnt_done(input logic [39:0] cnt, input logic [39:0] len);
        cnt_done = (len == 40'h0) || (cnt >= len - 40'h1);
    endfunction : cnt_done

    // Long capacitor periods saturate rather than wrap when scaled
    function automatic logic [39:0] scale_len(input logic [39:0] len, input logic [2:0] sh);
        logic [79:0] wide;
        wide      = {40'h0, len} << sh;
        scale_len = (wide[79:40] != 40'h0) ? 40'hffffffffff : wide[39:0];
    endfunction : scale_len

    // ------------------------------------------------------------
    // Configuration
    // ------------------------------------------------------------
    logic [39:0] cfg_cnt_ff;
    logic        cfg_done_ff;
    logic [15:0] code_ff;

    // The last code sampled before the window closes is the one kept
    always_ff @(posedge clk) begin // [RULE15]
        if (rst) begin
            cfg_cnt_ff  <= 40'h0;
            cfg_done_ff <= 1'b0;
            code_ff     <= 16'h0;
        end else if (!cfg_done_ff) begin
            code_ff <= threshold_program_inputs; // [RULE4]
            if (cnt_done(cfg_cnt_ff, CFG_CYCLES))
                cfg_done_ff <= 1'b1;
            else
                cfg_cnt_ff <= cfg_cnt_ff + 40'h1;
        end
    end

    // Negative-adjust channel is good while its input stays below 0.5V
    function automatic logic ch_good(input logic [3:0] code, input logic above);
        ch_good = (code == `QSRS_CODE_NEG_ADJ) ? !above : above; // [RULE3]
    endfunction : ch_good

    logic [3:0] good;
    always_comb begin
        for (int i = 0; i < 4; i++)
            good[i] = cfg_done_ff && ch_good(code_ff[i*4 +: 4], ch_ok_ff[i]);
    end
    logic all_good;
    assign all_good = &good;

    // ------------------------------------------------------------
    // Manual reset debounce
    // ------------------------------------------------------------
    logic [39:0] deb_cnt_ff;
    logic        mr_deb_ff;

    always_ff @(posedge clk) begin // [RULE6]
        if (rst) begin
            deb_cnt_ff <= 40'h0;
            mr_deb_ff  <= 1'b1;
        end else if (!mr_lvl_ff) begin
            mr_deb_ff  <= 1'b0;
            deb_cnt_ff <= 40'h0;
        end else if (!mr_deb_ff) begin
            if (cnt_done(deb_cnt_ff, DEB_CYCLES))
                mr_deb_ff <= 1'b1;
            else
                deb_cnt_ff <= deb_cnt_ff + 40'h1;
        end
    end

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    qsrs_pkg::qsrs_state_t st_ff, nxt_st;
    logic [39:0] rst_cnt_ff;
    logic [39:0] rst_len;
    logic        wdt_expire;
    logic        force_low;

    assign rst_len   = reset_delay_is_cap ? cap_reset_cycles : RST_CYCLES; // [RULE2]
    assign force_low = !all_good || !mr_deb_ff; // [RULE1] [RULE6] [RULE12]

    // HOLD waits for every cause of reset to clear before timing starts
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            qsrs_pkg::QSRS_ST_CONFIG: if (cfg_done_ff) nxt_st = qsrs_pkg::QSRS_ST_HOLD;
            qsrs_pkg::QSRS_ST_HOLD:   if (!force_low) nxt_st = qsrs_pkg::QSRS_ST_TIMING;
            qsrs_pkg::QSRS_ST_TIMING: begin
                if (force_low)
                    nxt_st = qsrs_pkg::QSRS_ST_HOLD;
                else if (cnt_done(rst_cnt_ff, rst_len))
                    nxt_st = qsrs_pkg::QSRS_ST_RUN; // [RULE2]
            end
            qsrs_pkg::QSRS_ST_RUN: begin
                if (force_low)
                    nxt_st = qsrs_pkg::QSRS_ST_HOLD;
                else if (wdt_expire)
                    nxt_st = qsrs_pkg::QSRS_ST_TIMING; // [RULE9]
            end
            default: nxt_st = qsrs_pkg::QSRS_ST_CONFIG;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) st_ff <= qsrs_pkg::QSRS_ST_CONFIG;
        else     st_ff <= nxt_st;
    end

    always_ff @(posedge clk) begin
        if (rst || st_ff != qsrs_pkg::QSRS_ST_TIMING)
            rst_cnt_ff <= 40'h0;
        else
            rst_cnt_ff <= rst_cnt_ff + 40'h1;
    end

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    logic        kick_d_ff;
    logic        first_ff;
    logic [39:0] wdt_cnt_ff;
    logic [39:0] upper_len, wdt_len;
    logic        kick_edge, wdt_on, run;

    assign run       = (st_ff == qsrs_pkg::QSRS_ST_RUN) && !force_low;
    assign kick_edge = kick_lvl_ff ^ kick_d_ff;
    assign wdt_on    = (watchdog_period_pin != qsrs_pkg::QSRS_PIN_GND); // [RULE16]
    assign upper_len = (watchdog_period_pin == qsrs_pkg::QSRS_PIN_SUPPLY) ?
                       WDT_CYCLES : cap_watchdog_cycles; // [RULE8]

    always_comb begin // [RULE10] [RULE13]
        wdt_len = upper_len;
        if (first_ff) begin
            case (initial_timeout_select)
                qsrs_pkg::QSRS_SEL_OPEN: wdt_len = scale_len(upper_len, 3'h3);
                qsrs_pkg::QSRS_SEL_HIGH: wdt_len = scale_len(upper_len, 3'h6);
                default:                 wdt_len = upper_len;
            endcase
        end
    end

    assign wdt_expire = wdt_on && run && !kick_edge && cnt_done(wdt_cnt_ff, wdt_len); // [RULE7]

    always_ff @(posedge clk) begin
        if (rst) kick_d_ff <= 1'b0;
        else     kick_d_ff <= kick_lvl_ff;
    end

    // Leaving the run state restarts the count at the initial length
    always_ff @(posedge clk) begin // [RULE14] [RULE18]
        if (rst || !run) begin
            wdt_cnt_ff <= 40'h0;
            first_ff   <= 1'b1;
        end else if (kick_edge) begin
            wdt_cnt_ff <= 40'h0;
            first_ff   <= 1'b0;
        end else if (wdt_expire) begin
            wdt_cnt_ff <= 40'h0;
        end else begin
            wdt_cnt_ff <= wdt_cnt_ff + 40'h1;
        end
    end

    // Fault stays latched through the reset timeout; a kick once running, undervoltage or a grounded period pin clears it
    always_ff @(posedge clk) begin // [RULE9] [RULE14]
        if (rst)
            watchdog_fault_n <= 1'b1;
        else if (wdt_expire)
            watchdog_fault_n <= 1'b0;
        else if (!wdt_on)
            watchdog_fault_n <= 1'b1; // [RULE16]
        else if (!all_good && cfg_done_ff)
            watchdog_fault_n <= 1'b1;
        else if (run && kick_edge)
            watchdog_fault_n <= 1'b1;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Inhibit wins over every reset source; the sequencer keeps running underneath
    always_ff @(posedge clk) begin
        if (rst)
            system_reset_n <= 1'b0;
        else
            system_reset_n <= !inh_lvl_ff || (nxt_st == qsrs_pkg::QSRS_ST_RUN); // [RULE5]
    end

    // Flags bypass the reset timeout on purpose
    always_ff @(posedge clk) begin
        if (rst)
            channel_good_flags <= 4'h0;
        else
            channel_good_flags <= good; // [RULE11]
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            threshold_codes <= 16'h0;
            config_done     <= 1'b0;
        end else begin
            threshold_codes <= code_ff;
            config_done     <= cfg_done_ff; // [RULE15]
        end
    end

endmodule : qsrs_supervisor
`default_nettype wire

// File: verif/qsrs_cpu_model.sv
// Purpose: supervised processor that toggles the watchdog kick
// Assumes: kicks only while out of reset and enabled by the bench
// Notes:   PERIOD must stay below the shortest watchdog timeout
`timescale 1ns/1ps
`default_nettype none
module qsrs_cpu_model #(
    parameter int PERIOD = 10
) (
    // Clock and control
    input  wire logic clk,
    input  wire logic enable,
    input  wire logic system_reset_n,
    // Kick line
    output var  logic watchdog_kick
);
    int cnt_ff = 0;
    initial watchdog_kick = 1'b0;
    always @(posedge clk) begin
        cnt_ff <= (enable && system_reset_n && cnt_ff < PERIOD - 1) ? cnt_ff + 1 : 0;
        if (enable && system_reset_n && cnt_ff == PERIOD - 1) begin
            watchdog_kick <= #1 ~watchdog_kick;
        end
    end
endmodule : qsrs_cpu_model
`default_nettype wire

// File: verif/qsrs_supervisor_chk.sv
// Purpose: port-level checks of the reset supervisor
// Assumes: one clock domain, rst synchronous
// Notes:   inhibit and manual inputs pass a short synchroniser first
`timescale 1ns/1ps
`default_nettype none
module qsrs_supervisor_chk #(
    parameter logic [39:0] RST_CYCLES = 40'h14
) (
    // Clock and reset
    input wire logic                clk,
    input wire logic                rst,
    // Observed inputs
    input wire logic [3:0]          above_threshold,
    input wire logic                manual_reset_n,
    input wire logic                reset_inhibit_n,
    input wire qsrs_pkg::qsrs_pin_t watchdog_period_pin,
    input wire logic                reset_delay_is_cap,
    input wire logic [39:0]         cap_reset_cycles,
    // Observed outputs
    input wire logic                system_reset_n,
    input wire logic                watchdog_fault_n,
    input wire logic [3:0]          channel_good_flags,
    input wire logic [15:0]         threshold_codes,
    input wire logic                config_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [39:0] ok_cnt_ff;
    logic [39:0] nxt_ok_cnt;
    logic [39:0] rlen;
    logic [3:0]  good_exp;
    // Saturating count of cycles with config done, manual reset high and every channel good
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            good_exp[i] = above_threshold[i] ^ (threshold_codes[4*i +: 4] == 4'h0);
        end
        rlen = reset_delay_is_cap ? cap_reset_cycles : RST_CYCLES;
        nxt_ok_cnt = 40'h0;
        if (config_done && manual_reset_n && good_exp == 4'hf) begin
            nxt_ok_cnt = ok_cnt_ff + ((ok_cnt_ff <= rlen + 40'h20) ? 40'h1 : 40'h0);
        end
    end
    always_ff @(posedge clk) begin
        ok_cnt_ff <= rst ? 40'h0 : nxt_ok_cnt;
    end
    a_fault_low:
    assert property (config_done && reset_inhibit_n && $past(reset_inhibit_n, 6)
        && channel_good_flags != 4'hf |-> ##[0:2] !system_reset_n) else $error("reset high in fault");
    a_release_count:
    assert property ($rose(system_reset_n) && reset_inhibit_n && $past(reset_inhibit_n, 6)
        |-> ok_cnt_ff >= rlen) else $error("reset released early");
    a_release_bound:
    assert property (ok_cnt_ff == rlen + 40'h10 && reset_inhibit_n && watchdog_fault_n
        |-> system_reset_n) else $error("reset released late");
    a_inhibit_high:
    assert property ((!reset_inhibit_n)[*6] |-> system_reset_n) else $error("inhibit ignored");
    a_config_hold:
    assert property (!config_done && reset_inhibit_n |-> !system_reset_n)
        else $error("reset high before configuration");
    a_manual_low:
    assert property ((!manual_reset_n && reset_inhibit_n)[*7] |-> !system_reset_n)
        else $error("manual reset ignored");
    a_flags_track:
    assert property ((config_done && $stable(good_exp))[*6] |-> channel_good_flags == good_exp)
        else $error("good flags wrong");
    a_wdt_forces:
    assert property ($fell(watchdog_fault_n) && reset_inhibit_n |-> ##[0:1] !system_reset_n)
        else $error("watchdog fault without reset");
    a_wdt_off:
    assert property (watchdog_period_pin == qsrs_pkg::QSRS_PIN_GND |-> watchdog_fault_n)
        else $error("watchdog fault while disabled");
endmodule : qsrs_supervisor_chk
bind qsrs_supervisor qsrs_supervisor_chk #(.RST_CYCLES(RST_CYCLES)) i_chk (
    .clk, .rst, .above_threshold, .manual_reset_n, .reset_inhibit_n, .watchdog_period_pin,
    .reset_delay_is_cap, .cap_reset_cycles, .system_reset_n, .watchdog_fault_n,
    .channel_good_flags, .threshold_codes, .config_done);
`default_nettype wire

// File: verif/test_quad_supply_reset_supervisor.sv
// Purpose: self-checking bench of the reset supervisor
// Assumes: shortened counts RST 20, WDT 30, CFG 10, DEB 4
// Notes:   channel 3 uses code 0, so it is good while its input is low
`timescale 1ns/1ps
`default_nettype none
module test_quad_supply_reset_supervisor;
    localparam int RST = 20;
    localparam int WDT = 30;
    logic                clk, rst, manual_reset_n, reset_inhibit_n, watchdog_kick;
    logic                reset_delay_is_cap, kick_en, system_reset_n, watchdog_fault_n, config_done;
    logic [3:0]          above_threshold, channel_good_flags;
    logic [15:0]         threshold_program_inputs, threshold_codes;
    logic [39:0]         cap_reset_cycles, cap_watchdog_cycles;
    qsrs_pkg::qsrs_sel_t initial_timeout_select;
    qsrs_pkg::qsrs_pin_t watchdog_period_pin;
    int                  n_errors = 0;
    int                  n_checks = 0;
    qsrs_supervisor #(.RST_CYCLES(40'h14), .WDT_CYCLES(40'h1e), .CFG_CYCLES(40'ha),
        .DEB_CYCLES(40'h4)) i_dut (.clk, .rst, .above_threshold, .threshold_program_inputs,
        .manual_reset_n, .reset_inhibit_n, .watchdog_kick, .initial_timeout_select,
        .watchdog_period_pin, .reset_delay_is_cap, .cap_reset_cycles, .cap_watchdog_cycles,
        .system_reset_n, .watchdog_fault_n, .channel_good_flags, .threshold_codes, .config_done);
    qsrs_cpu_model #(.PERIOD(10)) i_cpu (.clk, .enable(kick_en), .system_reset_n, .watchdog_kick);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val
    task automatic chk_span(input string what, input int lo, input int hi, input int got);
        n_checks++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : chk_span
    // Bounded wait on reset (0), watchdog fault (1) or config done (2)
    task automatic wait_on(input int s, input logic v, input int max, output int n);
        n = 0;
        while ((s == 0 ? system_reset_n : s == 1 ? watchdog_fault_n : config_done) !== v
               && n < max) begin
            step(1);
            n++;
        end
    endtask : wait_on
    task automatic t_power_up;
        int n;
        wait_on(2, 1'b1, 40, n);
        chk_span("config cycles", 10, 16, n);
        chk_val("codes", 16'h0f15, threshold_codes);
        chk_val("reset in config", 16'h0, {15'h0, system_reset_n});
        wait_on(0, 1'b1, 60, n);
        chk_span("power-up release", RST, RST + 10, n);
        chk_val("flags", 16'hf, {12'h0, channel_good_flags});
        $display("t_power_up done");
    endtask : t_power_up
    task automatic t_fault;
        int n;
        reset_delay_is_cap = 1'b1;
        for (int ch = 0; ch < 4; ch += 3) begin
            above_threshold[ch] = ~above_threshold[ch];
            wait_on(0, 1'b0, 10, n);
            chk_span("fault response", 0, 6, n);
            step(3);
            chk_val("fault flags", 16'hf & ~(16'h1 << ch), {12'h0, channel_good_flags});
            above_threshold[ch] = ~above_threshold[ch];
            wait_on(0, 1'b1, 40, n);
            chk_span("capacitor release", 12, 22, n);
        end
        reset_delay_is_cap = 1'b0;
        $display("t_fault done");
    endtask : t_fault
    task automatic t_inhibit;
        reset_inhibit_n = 1'b0;
        step(8);
        above_threshold[1] = 1'b0;
        step(10);
        chk_val("inhibited reset", 16'h1, {15'h0, system_reset_n});
        above_threshold[1] = 1'b1;
        step(40);
        reset_inhibit_n = 1'b1;
        step(8);
        chk_val("after inhibit", 16'h1, {15'h0, system_reset_n});
        $display("t_inhibit done");
    endtask : t_inhibit
    task automatic t_manual;
        int n;
        manual_reset_n = 1'b0;
        wait_on(0, 1'b0, 10, n);
        chk_span("manual response", 0, 7, n);
        step(20);
        manual_reset_n = 1'b1;
        wait_on(0, 1'b1, 60, n);
        chk_span("manual release", RST, RST + 16, n);
        $display("t_manual done");
    endtask : t_manual
    task automatic t_watchdog;
        int n;
        int exp;
        for (int i = 0; i < 4; i++) begin
            watchdog_period_pin = (i == 3) ? qsrs_pkg::QSRS_PIN_CAP : qsrs_pkg::QSRS_PIN_SUPPLY;
            initial_timeout_select = qsrs_pkg::qsrs_sel_t'(2'(i % 3));
            exp = (i == 3) ? 25 : WDT * (1 << (3 * i));
            kick_en = 1'b0;
            above_threshold[0] = 1'b0;
            step(10);
            chk_val("fault cleared", 16'h1, {15'h0, watchdog_fault_n});
            above_threshold[0] = 1'b1;
            wait_on(0, 1'b1, 60, n);
            wait_on(1, 1'b0, exp + 10, n);
            chk_span("initial timeout", exp - 2, exp + 4, n);
            step(1);
            chk_val("watchdog reset", 16'h0, {15'h0, system_reset_n});
            wait_on(0, 1'b1, 40, n);
            chk_span("watchdog reset len", RST - 1, RST + 4, n);
            chk_val("fault latched", 16'h0, {15'h0, watchdog_fault_n});
            if (i % 2 == 0) begin
                kick_en = 1'b1;
                wait_on(1, 1'b1, 30, n);
                chk_span("kick clears fault", 0, 16, n);
            end
        end
        above_threshold[0] = 1'b0;
        step(10);
        chk_val("undervoltage clears fault", 16'h1, {15'h0, watchdog_fault_n});
        watchdog_period_pin = qsrs_pkg::QSRS_PIN_GND;
        kick_en = 1'b0;
        above_threshold[0] = 1'b1;
        step(100);
        chk_val("disabled", 16'h3, {14'h0, watchdog_fault_n, system_reset_n});
        $display("t_watchdog done");
    endtask : t_watchdog
    task automatic test_done;
        $display("Checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    // Whole run needs about 2800 cycles
    initial begin
        #200us;
        n_errors++;
        test_done();
    end
    initial begin
        {rst, manual_reset_n, reset_inhibit_n, kick_en, reset_delay_is_cap} = 5'h1e;
        above_threshold = 4'h7;
        threshold_program_inputs = 16'h0f15;
        cap_reset_cycles = 40'hc;
        cap_watchdog_cycles = 40'h19;
        initial_timeout_select = qsrs_pkg::QSRS_SEL_LOW;
        watchdog_period_pin = qsrs_pkg::QSRS_PIN_SUPPLY;
        step(5);
        rst = 1'b0;
        t_power_up();
        t_fault();
        t_inhibit();
        t_manual();
        t_watchdog();
        test_done();
    end
endmodule : test_quad_supply_reset_supervisor
`default_nettype wire
